/* File: src/lst_pkg.sv */
/*
 package for the line scan trigger controller: register map, field codes,
 timing constants and the carrier structs.
 assumes a single 100 MHz clock and a plain strobe register port.
*/
package lst_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned LINE_MIN_NS = 1000;
    localparam int unsigned LINE_MIN_CYC = (LINE_MIN_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned AW = 4;
    localparam logic [AW-1:0] REG_ENC_CTRL = 4'h0;
    localparam logic [AW-1:0] REG_ENC_DROP = 4'h1;
    localparam logic [AW-1:0] REG_ENC_MULT = 4'h2;
    localparam logic [AW-1:0] REG_FRM_CTRL = 4'h3;
    localparam logic [AW-1:0] REG_FRM_LINES = 4'h4;
    localparam logic [AW-1:0] REG_STATUS = 4'h5;
    localparam logic [AW-1:0] REG_USED_CNT = 4'h6;
    localparam logic [AW-1:0] REG_IGN_CNT = 4'h7;
    localparam logic [AW-1:0] REG_REV_CNT = 4'h8;

    localparam logic [1:0] ORD_MULT_FIRST0 = 2'h0;
    localparam logic [1:0] ORD_DROP_FIRST = 2'h1;
    localparam logic [1:0] DIR_IGNORE = 2'h0;
    localparam logic [1:0] DIR_AB = 2'h1;
    localparam logic [1:0] DIR_BA = 2'h2;

    localparam logic [6:0] DET_LOW = 7'h01;
    localparam logic [6:0] DET_HIGH = 7'h02;
    localparam logic [6:0] DET_RISE = 7'h04;
    localparam logic [6:0] DET_FALL = 7'h08;
    localparam logic [6:0] DET_DUAL_RISE = 7'h20;
    localparam logic [6:0] DET_DUAL_FALL = 7'h40;

    localparam logic [1:0] SRC_AB = 2'h0;
    localparam logic [1:0] SRC_A = 2'h1;
    localparam logic [1:0] SRC_B = 2'h2;

    typedef enum logic [1:0] {F_IDLE, F_WAIT, F_RUN} frm_state_t;

    typedef struct packed {
        logic enc_en;
        logic [1:0] src;
        logic [1:0] order;
        logic [1:0] dir;
        logic auto_delay;
        logic [15:0] drop;
        logic [15:0] mult;
        logic frm_en;
        logic var_len;
        logic grab;
        logic [6:0] det;
        logic [23:0] lines;
    } cfg_t;

    typedef struct packed {
        logic line_trig;
        logic frame_start;
        logic frame_end;
        logic frame_active;
        logic used_ev;
        logic ignored_ev;
        logic rev_ovf_ev;
        logic too_fast_ev;
    } evt_t;
endpackage

/* File: src/line_scan_trigger_control.sv */
/*
 line scan trigger controller: shaft encoder stage producing camera line triggers,
 and virtual frame trigger stage choosing which line starts a host frame.
 assumes asynchronous encoder and trigger pins, a register port on i_mclk,
 and a frame capture path that consumes o_evt.frame_active per line trigger.
*/
// The strobed register port and the placing of the registers were decided locally.
// Summary of operation
// - encoder enable 1 turns encoder triggering on; each qualified edge gives one line
// - source A and B: any edge of either phase is a candidate trigger
// - drop count discards that many pulses between consecutive passed triggers
// - multiply factor makes that many line triggers per encoder pulse
// - order 1 drops then multiplies; 0 or 2 multiplies then drops
// - direction 0 ignores it, 1 A-then-B forward, 2 B-then-A forward
// - reverse steps count up, forward down; triggers only when count is zero
// - reverse counter overflow raises a sticky event
// - auto delay spaces close triggers out, flags line trigger too fast
// - line triggers run at all times, also outside a frame
// - fixed length stores exactly the programmed line count from the trigger line
// - variable length frame ends by trigger, never beyond the line maximum; here rise and fall modes end only at the line maximum
// - level and dual modes roll over while active; edge modes take one frame
// - frame trigger events only while a grab is active
// - at fixed frame end, active level starts the next frame at once
// - fixed mode: each trigger is counted used or ignored; here an input 2 trigger in dual mode, or a level mode start, is counted as neither
// - variable mode never issues ignored; each trigger starts or ends a frame; here a start trigger in a running frame, off its last line, does neither
// - frame trigger enable 1 turns external frame triggering on
// - detection codes 1 low, 2 high, 4 rise, 8 fall, 32/64 dual rise/fall
// - dual mode: input 1 starts the frame, input 2 ends it; here input 2 ends it only in variable length mode
// - trigger giving an image is used; one giving none is ignored
module line_scan_trigger_control #(
    parameter int REV_W = 8,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // pins
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_trig1,
    input wire logic i_trig2,
    // register port
    input wire logic [lst_pkg::AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // events and camera trigger
    output lst_pkg::evt_t o_evt
);
    typedef struct packed {
        lst_pkg::cfg_t cfg;
        logic [1:0] sa, sb, s1, s2;
        logic pa, pb, p1, p2;
        // all ones once the edge history holds real pin levels
        logic [2:0] vld;
        logic [REV_W-1:0] rev;
        logic [15:0] drop_cnt;
        logic [15:0] mult_left;
        logic [15:0] pend;
        logic [15:0] gap;
        lst_pkg::frm_state_t fst;
        logic [23:0] line_cnt;
        logic [CNT_W-1:0] used_cnt, ign_cnt;
        logic rev_ovf, too_fast;
        lst_pkg::evt_t evt;
        logic [31:0] rdata;
    } st_t;

    st_t r, nxt;

    // encoder stage decode, worked out afresh every cycle
    logic ea, eb, step;
    logic fwd, rvs, qual, pass;
    logic [15:0] mult_eff;
    // frame trigger decode
    logic lvl, t_start, t_end, edge_trig, fin;

    always_comb
    begin
        nxt = r;
        nxt.evt = '0;
        nxt.rdata = '0;
        // the second stage feeds both the decode and the edge history
        nxt.sa = {r.sa[0], i_enc_a};
        nxt.sb = {r.sb[0], i_enc_b};
        nxt.s1 = {r.s1[0], i_trig1};
        nxt.s2 = {r.s2[0], i_trig2};
        nxt.pa = r.sa[1];
        nxt.pb = r.sb[1];
        nxt.p1 = r.s1[1];
        nxt.p2 = r.s2[1];
        // history is cleared by reset, so it matches the pins only three cycles later
        nxt.vld = {r.vld[1:0], 1'b1};

        // encoder stage
        ea = (r.sa[1] != r.pa) && (r.cfg.src != lst_pkg::SRC_B);
        eb = (r.sb[1] != r.pb) && (r.cfg.src != lst_pkg::SRC_A);
        // an encoder resting off zero at reset must not look like a step
        if (!r.vld[2])
        begin
            ea = 1'b0;
            eb = 1'b0;
        end
        step = ea || eb;
        // quadrature: on an A edge, A leads when A now differs from B
        fwd = 1'b1;
        rvs = 1'b0;
        if (r.cfg.dir != lst_pkg::DIR_IGNORE)
        begin
            if (ea)
                fwd = ((r.sa[1] != r.sb[1]) == (r.cfg.dir == lst_pkg::DIR_AB));
            else
                fwd = ((r.sa[1] == r.sb[1]) == (r.cfg.dir == lst_pkg::DIR_AB));
            rvs = !fwd;
        end
        qual = 1'b0;
        // only the drop-first order works pass out; keep it defined in the other
        pass = 1'b0;
        if (r.cfg.enc_en && step)
        begin
            if (rvs)
            begin
                if (&r.rev)
                    nxt.rev_ovf = 1'b1;
                else
                    nxt.rev = r.rev + 1'b1;
            end
            else if (r.rev != '0)
                nxt.rev = r.rev - 1'b1;
            else
                qual = 1'b1;
        end
        mult_eff = (r.cfg.mult == '0) ? 16'h0001 : r.cfg.mult;
        // drop-first: drop counter gates encoder pulses, survivors multiply
        if (r.cfg.order == lst_pkg::ORD_DROP_FIRST)
        begin
            pass = 1'b0;
            if (qual)
            begin
                if (r.drop_cnt == '0)
                begin
                    pass = 1'b1;
                    nxt.drop_cnt = r.cfg.drop;
                end
                else
                    nxt.drop_cnt = r.drop_cnt - 1'b1;
            end
            if (pass)
                nxt.mult_left = r.mult_left + mult_eff;
            if (r.mult_left != '0 && r.pend == '0)
            begin
                nxt.mult_left = nxt.mult_left - 1'b1;
                nxt.pend = 16'h0001;
            end
        end
        else
        begin
            // multiply first: each multiplied pulse then meets the drop counter
            if (qual)
                nxt.mult_left = r.mult_left + mult_eff;
            if (r.mult_left != '0)
            begin
                nxt.mult_left = nxt.mult_left - 1'b1;
                if (r.drop_cnt == '0)
                begin
                    nxt.pend = r.pend + 1'b1;
                    nxt.drop_cnt = r.cfg.drop;
                end
                else
                    nxt.drop_cnt = r.drop_cnt - 1'b1;
            end
        end

        // line trigger output with optional minimum spacing; runs regardless of frames
        if (r.gap != '0)
            nxt.gap = r.gap - 1'b1;
        if (r.pend != '0)
        begin
            if (!r.cfg.auto_delay || r.gap == '0)
            begin
                nxt.pend = nxt.pend - 1'b1;
                nxt.evt.line_trig = 1'b1;
                nxt.gap = 16'(lst_pkg::LINE_MIN_CYC);
            end
            else if (!r.too_fast)
            begin
                nxt.too_fast = 1'b1;
                nxt.evt.too_fast_ev = 1'b1;
            end
        end
        if (!r.rev_ovf && nxt.rev_ovf)
            nxt.evt.rev_ovf_ev = 1'b1;

        // frame trigger decode
        lvl = 1'b0;
        t_start = 1'b0;
        t_end = 1'b0;
        edge_trig = 1'b0;
        unique case (r.cfg.det)
            lst_pkg::DET_LOW: lvl = !r.s1[1];
            lst_pkg::DET_HIGH: lvl = r.s1[1];
            lst_pkg::DET_RISE: edge_trig = r.s1[1] && !r.p1;
            lst_pkg::DET_FALL: edge_trig = !r.s1[1] && r.p1;
            lst_pkg::DET_DUAL_RISE:
            begin
                t_start = r.s1[1] && !r.p1;
                t_end = r.s2[1] && !r.p2;
            end
            lst_pkg::DET_DUAL_FALL:
            begin
                t_start = !r.s1[1] && r.p1;
                t_end = !r.s2[1] && r.p2;
            end
            default: ;
        endcase
        // the same holds for the frame trigger pins
        if (!r.vld[2])
        begin
            lvl = 1'b0;
            t_start = 1'b0;
            t_end = 1'b0;
            edge_trig = 1'b0;
        end
        if (!r.cfg.frm_en || !r.cfg.grab)
        begin
            lvl = 1'b0;
            t_start = 1'b0;
            t_end = 1'b0;
            edge_trig = 1'b0;
            nxt.fst = lst_pkg::F_IDLE;
        end
        fin = r.evt.line_trig && (r.line_cnt + 24'h000001 >= r.cfg.lines);

        unique case (r.fst)
            lst_pkg::F_IDLE:
                if (r.cfg.frm_en && r.cfg.grab)
                    nxt.fst = lst_pkg::F_WAIT;
            lst_pkg::F_WAIT:
                if (r.cfg.frm_en && r.cfg.grab && (edge_trig || t_start || lvl))
                begin
                    nxt.fst = lst_pkg::F_RUN;
                    nxt.line_cnt = '0;
                    nxt.evt.frame_start = 1'b1;
                    nxt.evt.used_ev = edge_trig || t_start;
                end
            lst_pkg::F_RUN:
            begin
                if (r.evt.line_trig)
                    nxt.line_cnt = r.line_cnt + 24'h000001;
                if (edge_trig || t_start)
                begin
                    if (r.cfg.var_len)
                        nxt.evt.used_ev = 1'b0;
                    else
                        nxt.evt.ignored_ev = 1'b1;
                end
                if (fin || (r.cfg.var_len && (t_end || ((r.cfg.det == lst_pkg::DET_LOW ||
                    r.cfg.det == lst_pkg::DET_HIGH) && !lvl))))
                begin
                    nxt.evt.frame_end = 1'b1;
                    nxt.evt.used_ev = r.cfg.var_len && t_end;
                    nxt.line_cnt = '0;
                    // roll over only for level and dual modes
                    if (lvl || (fin && (r.cfg.det == lst_pkg::DET_DUAL_RISE ||
                        r.cfg.det == lst_pkg::DET_DUAL_FALL) && !t_end))
                    begin
                        nxt.evt.frame_start = 1'b1;
                        nxt.fst = lst_pkg::F_RUN;
                        // a start trigger on the closing line opens this frame, so it counts as used
                        if (edge_trig || t_start)
                        begin
                            nxt.evt.ignored_ev = 1'b0;
                            nxt.evt.used_ev = 1'b1;
                        end
                    end
                    else if (edge_trig)
                    begin
                        // an edge on the closing line starts the next single frame instead of being lost
                        nxt.evt.frame_start = 1'b1;
                        nxt.evt.ignored_ev = 1'b0;
                        nxt.evt.used_ev = 1'b1;
                        nxt.fst = lst_pkg::F_RUN;
                    end
                    else
                        nxt.fst = lst_pkg::F_WAIT;
                end
            end
            default: nxt.fst = lst_pkg::F_IDLE;
        endcase
        if (!r.cfg.frm_en || !r.cfg.grab)
            nxt.fst = lst_pkg::F_IDLE;
        nxt.evt.frame_active = (nxt.fst == lst_pkg::F_RUN);
        if (nxt.evt.used_ev)
            nxt.used_cnt = r.used_cnt + 1'b1;
        if (nxt.evt.ignored_ev)
            nxt.ign_cnt = r.ign_cnt + 1'b1;

        // register port
        if (i_wr)
        begin
            unique case (i_addr)
                lst_pkg::REG_ENC_CTRL:
                begin
                    nxt.cfg.enc_en = i_wdata[0];
                    nxt.cfg.src = i_wdata[2:1];
                    nxt.cfg.order = i_wdata[4:3];
                    nxt.cfg.dir = i_wdata[6:5];
                    nxt.cfg.auto_delay = i_wdata[7];
                end
                lst_pkg::REG_ENC_DROP: nxt.cfg.drop = i_wdata[15:0];
                lst_pkg::REG_ENC_MULT: nxt.cfg.mult = i_wdata[15:0];
                lst_pkg::REG_FRM_CTRL:
                begin
                    nxt.cfg.frm_en = i_wdata[0];
                    nxt.cfg.var_len = i_wdata[1];
                    nxt.cfg.grab = i_wdata[2];
                    nxt.cfg.det = i_wdata[14:8];
                end
                lst_pkg::REG_FRM_LINES: nxt.cfg.lines = i_wdata[23:0];
                lst_pkg::REG_STATUS:
                begin
                    // write one to clear; a new flag event in the same cycle wins, but the count clear wins over a new count
                    if (i_wdata[0] && !(!r.rev_ovf && nxt.rev_ovf))
                        nxt.rev_ovf = 1'b0;
                    if (i_wdata[1] && !nxt.evt.too_fast_ev)
                        nxt.too_fast = 1'b0;
                    if (i_wdata[2])
                    begin
                        nxt.used_cnt = '0;
                        nxt.ign_cnt = '0;
                    end
                end
                default: ;
            endcase
        end
        if (i_rd)
        begin
            unique case (i_addr)
                lst_pkg::REG_ENC_CTRL: nxt.rdata = 32'({r.cfg.auto_delay, r.cfg.dir, r.cfg.order,
                    r.cfg.src, r.cfg.enc_en});
                lst_pkg::REG_ENC_DROP: nxt.rdata = 32'(r.cfg.drop);
                lst_pkg::REG_ENC_MULT: nxt.rdata = 32'(r.cfg.mult);
                lst_pkg::REG_FRM_CTRL: nxt.rdata = 32'({r.cfg.det, 5'h00, r.cfg.grab, r.cfg.var_len,
                    r.cfg.frm_en});
                lst_pkg::REG_FRM_LINES: nxt.rdata = 32'(r.cfg.lines);
                lst_pkg::REG_STATUS: nxt.rdata = 32'({r.fst == lst_pkg::F_RUN, r.too_fast, r.rev_ovf});
                lst_pkg::REG_USED_CNT: nxt.rdata = 32'(r.used_cnt);
                lst_pkg::REG_IGN_CNT: nxt.rdata = 32'(r.ign_cnt);
                lst_pkg::REG_REV_CNT: nxt.rdata = 32'(r.rev);
                default: nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r <= '0;
            r.cfg.mult <= 16'h0001;
            r.cfg.lines <= 24'h000001;
            r.cfg.det <= lst_pkg::DET_RISE;
            r.fst <= lst_pkg::F_IDLE;
        end
        else
            r <= nxt;
    end

    assign o_rdata = r.rdata;
    assign o_evt = r.evt;
endmodule

/* File: tb/lst_partner.sv */
/*
 partner model: quadrature shaft encoder on the web and the external frame trigger source.
 assumes one bench process calls its tasks, timed on i_mclk.
*/
module lst_partner (
    // clock
    input wire logic i_mclk,
    // pins towards the block
    output logic o_enc_a,
    output logic o_enc_b,
    output logic o_trig1,
    output logic o_trig2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos = 2'h0;
    initial
    begin
        o_enc_a = 1'b0;
        o_enc_b = 1'b0;
        o_trig1 = 1'b0;
        o_trig2 = 1'b0;
    end
    // gray steps: up means a leads b; edges five cycles apart, above the sync minimum
    task automatic step(input logic up, input int n);
        repeat (n)
        begin
            @(posedge i_mclk);
            pos = up ? pos + 2'h1 : pos - 2'h1;
            o_enc_a <= pos[1] ^ pos[0];
            o_enc_b <= pos[1];
            repeat (4) @(posedge i_mclk);
        end
    endtask
    // input 1 marks frame start, input 2 frame end in dual mode
    task automatic set(input logic t1, input logic t2);
        @(posedge i_mclk);
        o_trig1 <= t1;
        o_trig2 <= t2;
        repeat (4) @(posedge i_mclk);
    endtask
endmodule

/* File: tb/line_scan_trigger_control_sva.sv */
/*
 checker for the line scan trigger controller: frame events and read data timing.
 assumes it is bound to the top module and sees its ports only.
*/
module lst_checker (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // register port
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // events
    input wire lst_pkg::evt_t o_evt
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    a_start_sets_active: assert property (o_evt.frame_start |-> o_evt.frame_active)
        else $error("frame start without frame active");
    a_active_needs_start: assert property ($rose(o_evt.frame_active) |-> o_evt.frame_start)
        else $error("frame active rose without frame start");
    a_end_in_frame: assert property (o_evt.frame_end |-> $past(o_evt.frame_active))
        else $error("frame end outside a frame");
    a_fell_after_end: assert property ($fell(o_evt.frame_active) |-> o_evt.frame_end || $past(o_evt.frame_end, 1))
        else $error("frame active fell without frame end");
    a_end_single_pulse: assert property (o_evt.frame_end |=> !o_evt.frame_end)
        else $error("frame end longer than one cycle");
    a_used_marks_frame: assert property (o_evt.used_ev |-> o_evt.frame_start || o_evt.frame_end)
        else $error("used event without frame start or end");
    a_ignored_in_frame: assert property (o_evt.ignored_ev |-> o_evt.frame_active && !o_evt.frame_start)
        else $error("ignored event outside a running frame");
    a_one_verdict: assert property (!(o_evt.used_ev && o_evt.ignored_ev))
        else $error("trigger both used and ignored");
endmodule
bind line_scan_trigger_control lst_checker i_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_evt(o_evt));

/* File: tb/test_line_scan_trigger_control.sv */
/*
 testbench: random and corner encoder traffic, frame trigger modes, register reads.
 assumes the partner model drives all pins; a reset before each test clears the counts.
*/
module test_line_scan_trigger_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [lst_pkg::AW-1:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    lst_pkg::evt_t o_evt;
    logic enc_a, enc_b, trig1, trig2;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int lt, fl, st, en, ig, ov, tf, gap, mg, i, e, d, m, o, l;
    logic [6:0] codes [4] = '{lst_pkg::DET_LOW, lst_pkg::DET_HIGH, lst_pkg::DET_RISE, lst_pkg::DET_FALL};
    logic [6:0] duals [2] = '{lst_pkg::DET_DUAL_RISE, lst_pkg::DET_DUAL_FALL};
    always #5 i_mclk = ~i_mclk;
    lst_partner i_far (.i_mclk(i_mclk), .o_enc_a(enc_a), .o_enc_b(enc_b), .o_trig1(trig1), .o_trig2(trig2));
    // small reverse counter so overflow is reached in a few steps
    line_scan_trigger_control #(.REV_W(3)) i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_enc_a(enc_a),
        .i_enc_b(enc_b), .i_trig1(trig1), .i_trig2(trig2), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_evt(o_evt));
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            {lt, fl, st, en, ig, ov, tf, gap} <= '0;
            mg <= 1000;
        end
        else
        begin
            gap <= gap + 1;
            st <= st + int'(o_evt.frame_start === 1'b1);
            en <= en + int'(o_evt.frame_end === 1'b1);
            ig <= ig + int'(o_evt.ignored_ev === 1'b1);
            ov <= ov + int'(o_evt.rev_ovf_ev === 1'b1);
            tf <= tf + int'(o_evt.too_fast_ev === 1'b1);
            if (o_evt.line_trig === 1'b1)
            begin
                lt <= lt + 1;
                gap <= 0;
                fl <= fl + int'(o_evt.frame_active === 1'b1);
                if (lt > 0 && gap < mg)
                    mg <= gap;
            end
        end
    end
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", n, x, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] x);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk($sformatf("reg %0h", a), x, o_rdata);
    endtask
    task automatic rst();
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
    endtask
    task automatic enc(input logic [1:0] ord, input logic [1:0] dir, input logic ad);
        wr(lst_pkg::REG_ENC_CTRL, {24'h0, ad, dir, ord, lst_pkg::SRC_AB, 1'b1});
    endtask
    task automatic idle();
        repeat (20) @(posedge i_mclk);
    endtask
    function automatic int exp_lines(int e, int d, int m, int o);
        return (o == 1) ? ((e + d) / (d + 1)) * m : (e * m + d) / (d + 1);
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(17));
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rchk(lst_pkg::REG_ENC_CTRL, 32'h0);
        rchk(lst_pkg::REG_ENC_DROP, 32'h0);
        rchk(lst_pkg::REG_ENC_MULT, 32'h1);
        rchk(lst_pkg::REG_FRM_CTRL, 32'h400);
        rchk(lst_pkg::REG_FRM_LINES, 32'h1);
        rchk(4'hf, 32'h0);
        i_far.step(1'b1, 4);
        idle();
        chk("lines off", 0, lt);
        enc(2'h0, lst_pkg::DIR_IGNORE, 1'b0);
        i_far.step(1'b1, 4);
        idle();
        chk("lines on", 4, lt);
        $display("test reset and enable done");
        for (i = 0; i < 8; i++)
        begin
            e = (i < 2) ? 1 : 1 + $urandom % 6;
            d = (i < 2) ? 1 : $urandom % 4;
            m = (i < 2) ? 2 : 1 + $urandom % 3;
            o = (i < 2) ? i : i % 3;
            rst();
            wr(lst_pkg::REG_ENC_DROP, d);
            wr(lst_pkg::REG_ENC_MULT, m);
            enc(o[1:0], lst_pkg::DIR_IGNORE, 1'b0);
            i_far.step(1'b1, e);
            idle();
            chk("drop mult", exp_lines(e, d, m, o), lt);
        end
        $display("test drop and multiply done");
        for (i = 1; i < 3; i++)
        begin
            rst();
            enc(2'h0, i[1:0], 1'b0);
            i_far.step(i == 2, 5);
            rchk(lst_pkg::REG_REV_CNT, 5);
            i_far.step(i == 1, 5);
            idle();
            rchk(lst_pkg::REG_REV_CNT, 0);
            chk("lines unwind", 0, lt);
            i_far.step(i == 1, 3);
            idle();
            chk("lines fwd", 3, lt);
        end
        // direction is still B-then-A here, so A leading steps are reverse steps
        i_far.step(1'b1, 8);
        rchk(lst_pkg::REG_STATUS, 1);
        chk("ovf event", 1, ov);
        wr(lst_pkg::REG_STATUS, 1);
        rchk(lst_pkg::REG_STATUS, 0);
        $display("test direction done");
        rst();
        wr(lst_pkg::REG_ENC_MULT, 3);
        enc(2'h0, lst_pkg::DIR_IGNORE, 1'b1);
        i_far.step(1'b1, 1);
        repeat (400) @(posedge i_mclk);
        chk("delayed lines", 3, lt);
        chk("spacing ok", 1, mg >= lst_pkg::LINE_MIN_CYC - 1);
        chk("too fast event", 1, tf);
        rchk(lst_pkg::REG_STATUS, 2);
        $display("test auto delay done");
        rst();
        enc(2'h0, lst_pkg::DIR_IGNORE, 1'b0);
        wr(lst_pkg::REG_FRM_LINES, 3);
        wr(lst_pkg::REG_FRM_CTRL, 32'h401);
        i_far.set(1'b1, 1'b0);
        i_far.step(1'b1, 2);
        chk("starts no grab", 0, st);
        i_far.set(1'b0, 1'b0);
        wr(lst_pkg::REG_FRM_CTRL, 32'h405);
        i_far.set(1'b1, 1'b0);
        i_far.step(1'b1, 1);
        i_far.set(1'b0, 1'b0);
        i_far.set(1'b1, 1'b0);
        i_far.step(1'b1, 5);
        chk("fixed starts", 1, st);
        chk("fixed lines", 3, fl);
        chk("fixed ends", 1, en);
        chk("ignored", 1, ig);
        rchk(lst_pkg::REG_USED_CNT, 1);
        rchk(lst_pkg::REG_IGN_CNT, 1);
        $display("test fixed frame done");
        for (i = 0; i < 4; i++)
        begin
            l = (codes[i] == lst_pkg::DET_LOW || codes[i] == lst_pkg::DET_FALL) ? 0 : 1;
            rst();
            enc(2'h0, lst_pkg::DIR_IGNORE, 1'b0);
            wr(lst_pkg::REG_FRM_LINES, 3);
            i_far.set(!l, 1'b0);
            wr(lst_pkg::REG_FRM_CTRL, {17'h0, codes[i], 8'h05});
            i_far.set(l, 1'b0);
            i_far.step(1'b1, 7);
            i_far.set(!l, 1'b0);
            i_far.step(1'b1, 5);
            chk("roll over starts", (i < 2) ? 3 : 1, st);
        end
        for (i = 0; i < 2; i++)
        begin
            l = (i == 0);
            rst();
            enc(2'h0, lst_pkg::DIR_IGNORE, 1'b0);
            wr(lst_pkg::REG_FRM_LINES, 5);
            i_far.set(!l, !l);
            wr(lst_pkg::REG_FRM_CTRL, {17'h0, duals[i], 8'h07});
            i_far.set(l, !l);
            i_far.set(!l, !l);
            i_far.step(1'b1, 2);
            i_far.set(!l, l);
            i_far.set(!l, !l);
            i_far.step(1'b1, 2);
            chk("dual starts", 1, st);
            chk("dual ends", 1, en);
            chk("dual lines", 2, fl);
            chk("var ignored", 0, ig);
        end
        $display("test frame modes done");
        end_sim();
    end
endmodule
